/* psm_pkg.sv */
// Package for the printer engine status monitor: constants and carriers.
// Assumes a single 100 MHz core clock and synchronous sensor inputs.
package psm_pkg;

  // Clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Toner sensing cycle in microseconds (1.965 s)
  localparam longint unsigned SENSE_CYCLE_US = 64'd1965000;
  // Sensing cycle in clocks, rounded down as a longest time
  localparam longint unsigned SENSE_CYCLE_CYC = (SENSE_CYCLE_US * 64'd1000) / CLK_PERIOD_NS;
  // Stuck alarm after this many sensing cycles without change
  localparam int unsigned STUCK_CYCLES = 2;
  // Consecutive samples needed to set or clear toner low
  localparam logic [1:0] SAMPLE_RUN = 2'h2;
  // Default encounter length that counts as low (clocks), arbitrary
  localparam logic [31:0] LOW_ENC_DEF = 32'h0100_0000;
  // Counter width for timers
  localparam int unsigned CNT_W = 32;

  // Reset values
  localparam logic RST_LOW = 1'b0;
  localparam logic [CNT_W-1:0] RST_CNT = 32'h0;

  // Paper size codes
  typedef enum logic [3:0] {
    PSM_SZ_NONE = 4'h0,
    PSM_SZ_LETTER = 4'h1,
    PSM_SZ_EXEC = 4'h2,
    PSM_SZ_A4 = 4'h3,
    PSM_SZ_LEGAL14 = 4'h4,
    PSM_SZ_LEGAL13 = 4'h5,
    PSM_SZ_B5 = 4'h6,
    PSM_SZ_A5 = 4'h7,
    PSM_SZ_A6 = 4'h8,
    PSM_SZ_UNKNOWN = 4'hF
  } psm_size_e;

  // Toner sample phase, Gray coded
  typedef enum logic [1:0] {
    PSM_TS_IDLE = 2'b00,
    PSM_TS_ENC = 2'b01
  } psm_tstate_e;

  // Four cassette switches, first in bit 3
  typedef struct packed {
    logic size_switch_first;
    logic size_switch_second;
    logic size_switch_third;
    logic size_switch_fourth;
  } psm_sw_s;

  // Status reported to the engine processor
  typedef struct packed {
    logic cover_open_status;
    logic hv_enable;
    logic hv_supply_enable;
    logic toner_low;
    logic toner_alarm;
    logic size_valid;
    psm_size_e size_code;
  } psm_stat_s;

endpackage : psm_pkg

/* psm_monitor.sv */
// Engine status monitor: cover interlock, toner low qualify, cassette size.
// Assumes all sensor inputs are already synchronous to core_clk.
//
// Notes on behaviour
// - Open cover: flag it, cut all high voltage
// - Long magnet encounter means low sample
// - Two consecutive low samples set toner low
// - Two consecutive full samples clear toner low
// - No sensor change two cycles raises alarm
// - Drum stopped freezes sampling, counts and timer
// - Read size switches while cassette inserted
// - Decode switch pattern into paper size
`timescale 1ns/1ps
module psm_monitor (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cover_switch_open,
  input wire logic hv_request,
  input wire logic toner_magnet,
  input wire logic drum_running,
  input wire logic [31:0] low_encounter_cycles,
  input wire logic cassette_present,
  input wire psm_pkg::psm_sw_s size_switches,
  output psm_pkg::psm_stat_s status
);
  import psm_pkg::*;

  // Entire module state; one register holds it all
  // Counters are full width so the stuck span fits without a prescaler
  typedef struct packed {
    psm_stat_s stat; // Reported status, drives the port directly
    psm_tstate_e ts; // Encounter phase
    logic mag_prev; // Sensor level at the last running edge
    logic [CNT_W-1:0] enc_cnt; // Length of the current encounter
    logic [CNT_W-1:0] still_cnt; // Clocks since the last sensor change
    logic [1:0] low_run; // Consecutive low samples, saturating
    logic [1:0] full_run; // Consecutive full samples, saturating
  } psm_state_s;

  psm_state_s st_r; // Registered state
  psm_state_s st_nxt; // Next state

  // Size lookup; unmatched codes fall to unknown
  function automatic psm_size_e psm_decode(input logic [3:0] sw);
    case (sw)
      4'h7: psm_decode = PSM_SZ_LETTER;
      4'h5: psm_decode = PSM_SZ_EXEC;
      4'h3: psm_decode = PSM_SZ_A4;
      4'hE: psm_decode = PSM_SZ_LEGAL14;
      4'hB: psm_decode = PSM_SZ_LEGAL13;
      4'hD: psm_decode = PSM_SZ_B5;
      4'hC: psm_decode = PSM_SZ_A5;
      4'h9: psm_decode = PSM_SZ_A6;
      default: psm_decode = PSM_SZ_UNKNOWN;
    endcase
  endfunction : psm_decode

  // Next-state logic
  // Every field holds unless a branch below gives it a new value
  always_comb begin
    logic low_sample; // Finished sample was long
    logic sample_done; // A sample ended this cycle
    low_sample = 1'b0;
    sample_done = 1'b0;
    // Start from the held state
    st_nxt = st_r;
    // Interlock is combinational-free: one flop from switch to outputs
    st_nxt.stat.cover_open_status = cover_switch_open;
    st_nxt.stat.hv_enable = hv_request & ~cover_switch_open;
    st_nxt.stat.hv_supply_enable = ~cover_switch_open;
    // Toner path only runs while the drum turns
    if (drum_running) begin
      st_nxt.mag_prev = toner_magnet;
      // Stuck timer: restarts on any edge of the sensor
      // A sensor change also drops an alarm already raised
      // Limitation: the span is a package constant, far beyond a short run
      if (toner_magnet != st_r.mag_prev) begin
        st_nxt.still_cnt = RST_CNT;
        st_nxt.stat.toner_alarm = 1'b0;
      end else if (st_r.still_cnt < CNT_W'(SENSE_CYCLE_CYC * STUCK_CYCLES)) begin
        st_nxt.still_cnt = st_r.still_cnt + 32'h1;
      end else begin
        // Timer ran out: hold the count and raise the alarm
        st_nxt.stat.toner_alarm = 1'b1;
      end
      // Encounter measurement
      // Count starts on the first high sample and ends when the lever drops
      case (st_r.ts)
        // Waiting for the magnets to meet
        PSM_TS_IDLE: begin
          if (toner_magnet) begin
            st_nxt.ts = PSM_TS_ENC;
            st_nxt.enc_cnt = 32'h1;
          end
        end
        // Magnets in encounter
        PSM_TS_ENC: begin
          if (toner_magnet) begin
            // Saturate so very long encounters stay low
            if (st_r.enc_cnt != 32'hFFFF_FFFF) begin
              st_nxt.enc_cnt = st_r.enc_cnt + 32'h1;
            end
          end else begin
            // Lever released: this ends one toner sample
            st_nxt.ts = PSM_TS_IDLE;
            sample_done = 1'b1;
            low_sample = st_r.enc_cnt >= low_encounter_cycles;
          end
        end
        default: st_nxt.ts = PSM_TS_IDLE;
      endcase
      // Hysteresis on sample runs
      // Runs saturate at the needed count so a long streak cannot wrap
      // A sample of the other kind restarts the opposite run
      if (sample_done) begin
        // Low sample: one more low, full run broken
        if (low_sample) begin
          st_nxt.full_run = 2'h0;
          st_nxt.low_run = (st_r.low_run == SAMPLE_RUN) ? SAMPLE_RUN : st_r.low_run + 2'h1;
          if (st_r.low_run + 2'h1 >= SAMPLE_RUN) st_nxt.stat.toner_low = 1'b1;
        end else begin
          // Full sample: one more full, low run broken
          st_nxt.low_run = 2'h0;
          st_nxt.full_run = (st_r.full_run == SAMPLE_RUN) ? SAMPLE_RUN : st_r.full_run + 2'h1;
          if (st_r.full_run + 2'h1 >= SAMPLE_RUN) st_nxt.stat.toner_low = 1'b0;
        end
      end
    end
    // Size read only with a cassette in place
    // Tabs are not driven without a cassette, so their pattern is ignored then
    if (cassette_present) begin
      st_nxt.stat.size_code = psm_decode(size_switches);
      st_nxt.stat.size_valid = (psm_decode(size_switches) != PSM_SZ_UNKNOWN);
    end else begin
      // No cassette: no size
      st_nxt.stat.size_code = PSM_SZ_NONE;
      st_nxt.stat.size_valid = 1'b0;
    end
  end

  // State register
  // Async reset clears status, so high voltage is off while reset is held
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0; // High voltage off until first clock
    end else begin
      st_r <= st_nxt;
    end
  end

  // Port is the registered copy: no logic after the flop
  assign status = st_r.stat;

  // Cover open forces high voltage off next cycle
  a_cover_hv_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    cover_switch_open |=> (status.cover_open_status && !status.hv_enable && !status.hv_supply_enable))
    else $error("high voltage not cut on open cover");
  // Low flag needs a prior low run
  a_low_set_run: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(status.toner_low) |-> $past(st_r.low_run) >= 2'h1)
    else $error("toner low set without two low samples");
  // Clear needs a prior full run
  a_low_clr_run: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(status.toner_low) |-> $past(st_r.full_run) >= 2'h1)
    else $error("toner low cleared without two full samples");
  // Stopped drum freezes toner state
  a_drum_freeze: assert property (@(posedge core_clk) disable iff (!reset_n)
    !drum_running |=> $stable(st_r.still_cnt) && $stable(status.toner_low))
    else $error("toner logic moved while drum stopped");
  // Alarm only after the full stuck time
  a_alarm_time: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(status.toner_alarm) |-> st_r.still_cnt == CNT_W'(SENSE_CYCLE_CYC * STUCK_CYCLES))
    else $error("alarm raised early");
  // Letter decode
  a_size_letter: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cassette_present && size_switches == 4'h7) |=> status.size_code == PSM_SZ_LETTER)
    else $error("letter pattern misdecoded");
  // Undefined pattern flagged
  a_size_unknown: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cassette_present && size_switches == 4'h0) |=> !status.size_valid)
    else $error("undefined pattern reported valid");
  // No cassette gives no size
  a_size_absent: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cassette_present |=> status.size_code == PSM_SZ_NONE)
    else $error("size reported without cassette");
  // No request keeps the transfer output off
  a_hv_request_off: assert property (@(posedge core_clk) disable iff (!reset_n)
    !hv_request |=> !status.hv_enable)
    else $error("high voltage on without a request");
  // Closed cover restores the supply feed
  a_supply_closed: assert property (@(posedge core_clk) disable iff (!reset_n)
    !cover_switch_open |=> (status.hv_supply_enable && !status.cover_open_status))
    else $error("supply feed cut with cover closed");
  // Long encounter after a low sample sets the flag
  a_low_sample: assert property (@(posedge core_clk) disable iff (!reset_n)
    (drum_running && st_r.ts == PSM_TS_ENC && !toner_magnet && st_r.low_run != 2'h0 &&
      st_r.enc_cnt >= low_encounter_cycles) |=> status.toner_low)
    else $error("long encounter not taken as low");
  // Short encounter after a full sample clears the flag
  a_full_sample: assert property (@(posedge core_clk) disable iff (!reset_n)
    (drum_running && st_r.ts == PSM_TS_ENC && !toner_magnet && st_r.full_run != 2'h0 &&
      st_r.enc_cnt < low_encounter_cycles) |=> !status.toner_low)
    else $error("short encounter not taken as full");
  // No alarm before the stuck timer has run out
  a_alarm_early: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_r.still_cnt < CNT_W'(SENSE_CYCLE_CYC * STUCK_CYCLES)) |-> !status.toner_alarm)
    else $error("alarm raised before stuck time");
  // A sensor change while running drops the alarm
  a_alarm_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
    (drum_running && (toner_magnet != st_r.mag_prev)) |=> !status.toner_alarm)
    else $error("alarm kept after sensor change");
  // Stopped drum also holds the sample runs and phase
  a_run_freeze: assert property (@(posedge core_clk) disable iff (!reset_n)
    !drum_running |=> ($stable(st_r.low_run) && $stable(st_r.full_run) && $stable(st_r.ts)))
    else $error("sample runs moved while drum stopped");
  // A4 decode, reported as a valid size
  a_size_a4: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cassette_present && size_switches == 4'h3) |=>
      (status.size_code == PSM_SZ_A4 && status.size_valid))
    else $error("a4 pattern misdecoded");

endmodule : psm_monitor

/* psm_sensor_model.sv */
// Far-side model of the toner magnet sensor lever.
// Assumes it is called just after a rising edge of core_clk.
`timescale 1ns/1ps
module psm_sensor_model (
  input wire logic core_clk,
  output logic toner_magnet
);
  // Lever starts out of encounter
  initial toner_magnet = 1'b0;
  // Encounter held n clocks, then a settle gap for the sample to land
  task automatic encounter(input int n);
    toner_magnet = 1'b1;
    repeat (n) @(posedge core_clk);
    #1;
    toner_magnet = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : encounter
endmodule : psm_sensor_model

/* printer_engine_status_monitor_tb.sv */
// Self-checking bench for the engine status monitor.
// Assumes a 100 MHz core_clk; the stuck alarm span is far beyond this run.
`timescale 1ns/1ps
module printer_engine_status_monitor_tb;
  import psm_pkg::*;
  logic core_clk, reset_n, cover_switch_open, hv_request, drum_running, cassette_present;
  logic toner_magnet;
  logic [31:0] low_encounter_cycles;
  psm_sw_s size_switches;
  psm_stat_s status;
  int errors = 0;
  int samples_checked = 0;
  // Switch patterns, first switch in bit 3, last two outside the table
  logic [3:0] pats [10] = '{4'h7, 4'h5, 4'h3, 4'hE, 4'hB, 4'hD, 4'hC, 4'h9, 4'hF, 4'h0};
  psm_size_e codes [10] = '{PSM_SZ_LETTER, PSM_SZ_EXEC, PSM_SZ_A4, PSM_SZ_LEGAL14,
    PSM_SZ_LEGAL13, PSM_SZ_B5, PSM_SZ_A5, PSM_SZ_A6, PSM_SZ_UNKNOWN, PSM_SZ_UNKNOWN};

  psm_monitor psm_monitor_i (.core_clk(core_clk), .reset_n(reset_n),
    .cover_switch_open(cover_switch_open), .hv_request(hv_request),
    .toner_magnet(toner_magnet), .drum_running(drum_running),
    .low_encounter_cycles(low_encounter_cycles), .cassette_present(cassette_present),
    .size_switches(size_switches), .status(status));
  psm_sensor_model psm_sensor_model_i (.core_clk(core_clk), .toner_magnet(toner_magnet));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Inputs move one ns after the edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : check_bit
  task automatic check_size(input psm_size_e got, input psm_size_e exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t size code %h", $time, got);
    end
  endtask : check_size
  task automatic close_out;
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Hang guard, some fourteen times the expected run
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    cover_switch_open = 1'b0;
    hv_request = 1'b1;
    drum_running = 1'b1;
    cassette_present = 1'b1;
    low_encounter_cycles = 32'h0000_0010;
    size_switches = 4'h7;
    tick(20);
    check_bit(status.hv_enable, 1'b0, "hv on in reset");
    reset_n = 1'b1;
    tick(3);
    check_bit(status.hv_supply_enable, 1'b1, "supply off");
    check_bit(status.hv_enable, 1'b1, "hv off");
    // Cover open cuts both high-voltage outputs
    cover_switch_open = 1'b1;
    tick(2);
    check_bit(status.cover_open_status, 1'b1, "cover flag");
    check_bit(status.hv_enable, 1'b0, "hv kept");
    check_bit(status.hv_supply_enable, 1'b0, "supply kept");
    cover_switch_open = 1'b0;
    tick(2);
    check_bit(status.cover_open_status, 1'b0, "cover stuck");
    check_bit(status.hv_enable, 1'b1, "hv not restored");
    // Dropped request turns transfer off but leaves the supply feed
    hv_request = 1'b0;
    tick(2);
    check_bit(status.hv_enable, 1'b0, "hv without request");
    check_bit(status.hv_supply_enable, 1'b1, "supply dropped");
    hv_request = 1'b1;
    // Every size pattern plus two outside the table
    for (int i = 0; i < 10; i++) begin
      size_switches = pats[i];
      tick(2);
      check_size(status.size_code, codes[i]);
      check_bit(status.size_valid, i < 8, "size valid");
    end
    // Cassette out: no size reported
    cassette_present = 1'b0;
    tick(2);
    check_size(status.size_code, PSM_SZ_NONE);
    check_bit(status.size_valid, 1'b0, "size without cassette");
    cassette_present = 1'b1;
    // Boundary lengths: 16 clocks is low, 15 is full
    psm_sensor_model_i.encounter(16);
    check_bit(status.toner_low, 1'b0, "low on one");
    psm_sensor_model_i.encounter(16);
    check_bit(status.toner_low, 1'b1, "low not set");
    psm_sensor_model_i.encounter(15);
    psm_sensor_model_i.encounter(16);
    psm_sensor_model_i.encounter(15);
    check_bit(status.toner_low, 1'b1, "cleared early");
    psm_sensor_model_i.encounter(15);
    check_bit(status.toner_low, 1'b0, "not cleared");
    // Stopped drum: samples ignored
    drum_running = 1'b0;
    psm_sensor_model_i.encounter(16);
    psm_sensor_model_i.encounter(16);
    drum_running = 1'b1;
    tick(1);
    psm_sensor_model_i.encounter(16);
    check_bit(status.toner_low, 1'b0, "sampled while stopped");
    psm_sensor_model_i.encounter(16);
    check_bit(status.toner_low, 1'b1, "low after resume");
    // Raised threshold: 16-clock encounters now count as full
    low_encounter_cycles = 32'h0000_0020;
    psm_sensor_model_i.encounter(16);
    psm_sensor_model_i.encounter(16);
    check_bit(status.toner_low, 1'b0, "threshold ignored");
    psm_sensor_model_i.encounter(32);
    psm_sensor_model_i.encounter(32);
    check_bit(status.toner_low, 1'b1, "low at new threshold");
    check_bit(status.toner_alarm, 1'b0, "alarm early");
    close_out();
  end
endmodule : printer_engine_status_monitor_tb
